//--- rtl/oep_pkg.sv
// constants and types for the otp eprom programmer controller
// assumes a 10 MHz system clock; supply switches driven as logic levels
// Notes on behaviour
// - each program pulse is one strobe pulse, 50 us
// - pulse width kept within 47.5 to 52.5 us
// - select first address, raise core, then vpp
// - first pass: one pulse per address, no verify
// - verify pass retries up to ten pulses
// - fail whole part after tenth retry mismatch
// - advance on good verify until array done
// - drop vpp, core to 5v, read compare all
// - core supply on first, off in the same cycle as vpp after a good verify pass
// - id mode: upper lines low, high voltage line
package oep_pkg;
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned PULSE_NS     = 50_000;   // nominal program pulse
  localparam int unsigned PULSE_CYC    = PULSE_NS / (1_000_000_000 / CLK_HZ);
  localparam int unsigned SETUP_NS     = 2_000;    // generic 2 us setup/hold
  localparam int unsigned SETUP_CYC    = (SETUP_NS + 99) / (1_000_000_000 / CLK_HZ);
  localparam int unsigned LATCH_NS     = 500;      // strobe width for latching
  localparam int unsigned LATCH_CYC    = (LATCH_NS + 99) / (1_000_000_000 / CLK_HZ);
  localparam int unsigned PW_MIN_CYC   = 47_500 / (1_000_000_000 / CLK_HZ); // shortest pulse
  localparam int unsigned PW_MAX_CYC   = 52_500 / (1_000_000_000 / CLK_HZ); // longest pulse
  localparam int unsigned MAX_PULSES   = 10;
  localparam logic [3:0]  MAX_PULSES_4 = 4'ha;
  localparam logic [15:0] ADDR_RESET   = 16'h0000;

  typedef enum logic [3:0] {
    OEP_IDLE   = 4'h0,
    OEP_PWRUP  = 4'h1,
    OEP_ADDR   = 4'h2,
    OEP_LATCH  = 4'h3,
    OEP_DATA   = 4'h4,
    OEP_PULSE  = 4'h5,
    OEP_VFY    = 4'h6,
    OEP_NEXT   = 4'h7,
    OEP_PWRDN  = 4'h8,
    OEP_READ   = 4'h9,
    OEP_DONE   = 4'ha,
    OEP_ID     = 4'hb
  } oep_state_t;
endpackage : oep_pkg

//--- rtl/oep_tmr_if.sv
// timer request/status bundle between controller and its delay timer
// assumes one clock domain
`timescale 1ns/1ps
interface oep_tmr_if;
  logic        start;
  logic [15:0] count;
  logic        done;
  modport ctl (output start, output count, input done);
  modport tmr (input start, input count, output done);
endinterface : oep_tmr_if

//--- rtl/oep_timer.sv
// down-counting delay timer, one-cycle done pulse
// assumes start is a one-cycle pulse from the controller
`timescale 1ns/1ps
module oep_timer
  import oep_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk_in,
  input  wire logic reset_in,
  // request
  oep_tmr_if.tmr    tmr
);
  logic [15:0] cnt;
  logic        run;
  logic [15:0] next_cnt;
  logic        next_run;
  logic        next_done;
  logic        done_q;

  // count down; done fires as count reaches zero
  always_comb
  begin
    next_cnt  = cnt;
    next_run  = run;
    next_done = 1'b0;
    if (tmr.start)
    begin
      next_cnt = tmr.count;
      next_run = 1'b1;
    end
    else if (run)
    begin
      if (cnt <= 16'h0001)
      begin
        next_run  = 1'b0;
        next_done = 1'b1;
      end
      else
        next_cnt = cnt - 16'h0001;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      cnt    <= 16'h0000;
      run    <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      cnt    <= next_cnt;
      run    <= next_run;
      done_q <= next_done;
    end
  end

  assign tmr.done = done_q;
endmodule : oep_timer

//--- rtl/oep_prog.sv
// otp eprom programmer: program, verify/retry, read-back and id read
// assumes data source answers src_data_in for src_addr_out combinationally
// assumes pins bidirectional lines resolved outside; inputs are async
`timescale 1ns/1ps
module oep_prog
  import oep_pkg::*;
#(
  parameter logic [16:0] LAST_ADDR = 17'h0ffff
)(
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        reset_in,
  // user control
  input  wire logic        start_in,
  input  wire logic        id_req_in,
  input  wire logic        id_sel_in,
  input  wire logic [7:0]  src_data_in,
  output logic [15:0]      src_addr_out,
  output logic             busy_out,
  output logic             pass_out,
  output logic             fail_out,
  output logic [7:0]       id_code_out,
  // device pins
  output logic             strobe_out,
  output logic             vcc_high_out,
  output logic             vcc_low_out,
  output logic             vpp_high_out,
  output logic             oe_n_out,
  output logic [7:0]       upper_address_lines_out,
  output logic             id_select_line_out,
  output logic             id_mode_high_voltage_line_out,
  input  wire logic [7:0]  muxed_low_address_data_lines_in,
  output logic [7:0]       muxed_low_address_data_lines_out,
  output logic             muxed_low_address_data_lines_oe_out
);
  oep_tmr_if t ();
  oep_timer u_tmr (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .tmr(t));

  oep_state_t  st, next_st, ret, next_ret;
  logic [15:0] addr, next_addr;
  logic [3:0]  tries, next_tries;
  logic        verify, next_verify;   // 0 first pass, 1 verify pass
  logic [1:0]  step, next_step;
  logic        pass, next_pass, fail, next_fail;
  logic [7:0]  idc, next_idc;
  logic [7:0]  rd_s1, rd_s2;
  logic        go;
  logic [15:0] go_cnt;
  logic [15:0] pw_cnt, next_pw_cnt;

  // two stages on the returning data lines
  always_ff @(posedge sys_clk_in)
  begin
    rd_s1 <= muxed_low_address_data_lines_in;
    rd_s2 <= rd_s1;
  end

  function automatic logic is_last(input logic [15:0] a);
    return {1'b0, a} == LAST_ADDR;
  endfunction : is_last

  // sequencing; each wait goes through the shared timer
  always_comb
  begin
    next_st = st; next_ret = ret; next_addr = addr; next_tries = tries;
    next_verify = verify; next_step = step; next_pass = pass; next_fail = fail;
    next_idc = idc; go = 1'b0; go_cnt = 16'(SETUP_CYC);
    case (st)
      OEP_IDLE:
        if (start_in)
        begin
          next_addr = ADDR_RESET; next_verify = 1'b0; next_pass = 1'b0;
          next_fail = 1'b0; next_step = 2'd0; next_st = OEP_PWRUP; go = 1'b1;
          next_tries = 4'h0; next_ret = OEP_DATA;  // no count left from a failed run
        end
        else if (id_req_in)
        begin
          next_st = OEP_ID; next_step = 2'd0; go = 1'b1;
        end
      OEP_PWRUP:   // core first, vpp after a setup gap
        if (t.done)
        begin
          if (step == 2'd0)
          begin
            next_step = 2'd1; go = 1'b1;
          end
          else
          begin
            next_st = OEP_ADDR; go = 1'b1;
          end
        end
      OEP_ADDR:
        if (t.done)
        begin
          next_st = OEP_LATCH; go = 1'b1; go_cnt = 16'(LATCH_CYC);
        end
      OEP_LATCH:
        if (t.done)
        begin
          next_st = ret; go = 1'b1;
        end
      OEP_DATA:
        if (t.done)
        begin
          next_st = OEP_PULSE; go = 1'b1; go_cnt = 16'(PULSE_CYC);
          next_tries = tries + 4'h1;
        end
      OEP_PULSE:
        if (t.done)
        begin
          go = 1'b1;
          next_st = verify ? OEP_VFY : OEP_NEXT;
        end
      OEP_VFY:
        if (t.done)
        begin
          if (rd_s2 == src_data_in)
          begin
            next_st = OEP_NEXT; go = 1'b1;
          end
          else if (tries >= MAX_PULSES_4)
          begin
            next_fail = 1'b1; next_st = OEP_PWRDN; go = 1'b1;
          end
          else
          begin
            next_st = OEP_ADDR; next_ret = OEP_DATA; go = 1'b1;
          end
        end
      OEP_NEXT:
        if (t.done)
        begin
          next_tries = 4'h0; go = 1'b1;
          // every read needs its low address latched first
          next_st = OEP_ADDR; next_ret = OEP_VFY;
          if (is_last(addr))
          begin
            next_addr = ADDR_RESET;
            if (!verify)
              next_verify = 1'b1;
            else
              next_st = OEP_PWRDN;
          end
          else
          begin
            next_addr = addr + 16'h0001;
            if (!verify)
              next_ret = OEP_DATA;
          end
        end
      OEP_PWRDN:   // core drops here; vpp drops with it from OEP_NEXT, but is already low after a failed verify
        if (t.done)
        begin
          if (fail)
            next_st = OEP_DONE;
          else
          begin
            next_addr = ADDR_RESET; next_st = OEP_ADDR; go = 1'b1;
            next_ret = OEP_READ;
          end
        end
      OEP_READ:
        if (t.done)
        begin
          if (rd_s2 != src_data_in)
            next_fail = 1'b1;
          if (is_last(addr))
          begin
            next_pass = (rd_s2 == src_data_in) && !fail; next_st = OEP_DONE;
          end
          else
          begin
            next_addr = addr + 16'h0001; next_st = OEP_ADDR; go = 1'b1;
          end
        end
      OEP_ID:
        if (t.done)
        begin
          next_idc = rd_s2; next_st = OEP_DONE;
        end
      OEP_DONE:
        if (!start_in && !id_req_in)
          next_st = OEP_IDLE;
      default:
        next_st = OEP_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      st <= OEP_IDLE; ret <= OEP_IDLE; addr <= ADDR_RESET; tries <= 4'h0;
      verify <= 1'b0; step <= 2'd0; pass <= 1'b0; fail <= 1'b0;
      idc <= 8'h00;
    end
    else
    begin
      st <= next_st; ret <= next_ret; addr <= next_addr; tries <= next_tries;
      verify <= next_verify; step <= next_step; pass <= next_pass;
      fail <= next_fail; idc <= next_idc;
    end
  end

  assign t.start = go;
  assign t.count = go_cnt;

  // pin drive decoded from state; programming phases hold 6.5v/13v
  logic prog_ph;
  assign prog_ph = (((st == OEP_ADDR) || (st == OEP_LATCH)) && (ret != OEP_READ)) ||
                   (st == OEP_DATA) || (st == OEP_PULSE) || (st == OEP_NEXT) ||
                   (st == OEP_PWRUP && step == 2'd1);
  assign vcc_high_out  = prog_ph || st == OEP_PWRUP || st == OEP_VFY;
  assign vpp_high_out  = prog_ph;
  assign vcc_low_out   = !vcc_high_out;
  assign oe_n_out      = !(st == OEP_VFY || st == OEP_READ || st == OEP_ID);
  assign strobe_out    = !((st == OEP_LATCH) || (st == OEP_PULSE));
  assign upper_address_lines_out = (st == OEP_ID) ? 8'h00 : addr[15:8];
  assign id_select_line_out      = (st == OEP_ID) ? id_sel_in : addr[8];
  assign id_mode_high_voltage_line_out = (st == OEP_ID);
  assign muxed_low_address_data_lines_out =
    (st == OEP_DATA || st == OEP_PULSE) ? src_data_in : addr[7:0];
  assign muxed_low_address_data_lines_oe_out = oe_n_out;
  assign src_addr_out = addr;
  assign busy_out     = (st != OEP_IDLE) && (st != OEP_DONE);
  assign pass_out     = pass;
  assign fail_out     = fail;
  assign id_code_out  = idc;

  // cycles spent in the current program pulse; a long one overstresses the cell
  always_comb
  begin
    next_pw_cnt = 16'h0000;
    if (st == OEP_PULSE)
      next_pw_cnt = pw_cnt + 16'h0001;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
      pw_cnt <= 16'h0000;
    else
      pw_cnt <= next_pw_cnt;
  end

  property p_pulse;
    @(posedge sys_clk_in) disable iff (reset_in)
    (st == OEP_PULSE) && t.done |->
      (pw_cnt >= 16'(PW_MIN_CYC - 1)) && (pw_cnt <= 16'(PW_MAX_CYC - 1));
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse width out of range");
  property p_vpp_core;
    @(posedge sys_clk_in) disable iff (reset_in)
    vpp_high_out |-> vcc_high_out;
  endproperty
  a_vpp_core: assert property (p_vpp_core) else $error("vpp without core");
  property p_power_order;
    @(posedge sys_clk_in) disable iff (reset_in)
    $rose(vpp_high_out) |-> $past(vcc_high_out);
  endproperty
  a_power_order: assert property (p_power_order) else $error("vpp rose before core");
  property p_idle_safe;
    @(posedge sys_clk_in) disable iff (reset_in)
    (st == OEP_IDLE) |-> strobe_out && !vpp_high_out && !vcc_high_out;
  endproperty
  a_idle_safe: assert property (p_idle_safe) else $error("pins not idle");
  property p_tries;
    @(posedge sys_clk_in) disable iff (reset_in)
    tries <= MAX_PULSES_4;
  endproperty
  a_tries: assert property (p_tries) else $error("too many pulses");
  property p_idmode;
    @(posedge sys_clk_in) disable iff (reset_in)
    (st == OEP_ID) |-> upper_address_lines_out == 8'h00;
  endproperty
  a_idmode: assert property (p_idmode) else $error("id upper lines high");
  // address on the lines as the latch closes, data byte in the next cycle
  sequence s_latch_for_data;
    (st == OEP_LATCH) && t.done && (ret == OEP_DATA) &&
      (muxed_low_address_data_lines_out == addr[7:0]);
  endsequence
  sequence s_data_driven;
    muxed_low_address_data_lines_oe_out && (muxed_low_address_data_lines_out == src_data_in);
  endsequence
  property p_addr_then_data;
    @(posedge sys_clk_in) disable iff (reset_in)
    s_latch_for_data |=> s_data_driven;
  endproperty
  a_addr_then_data: assert property (p_addr_then_data) else $error("data not after latch");
endmodule : oep_prog

//--- dv/oep_dev_model.sv
// behavioural model of the otp eprom as seen at its programming pins
// assumes strobe idles high, so pulses are low; lines without pull resolve here
`timescale 1ns/1ps
module oep_dev_model #(
  parameter logic [7:0] MAKER_CODE  = 8'h5c, // arbitrary value
  parameter logic [7:0] DEVICE_CODE = 8'h3a  // arbitrary value
)(
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       reset_in,
  // device pins
  input  wire logic       strobe_in,
  input  wire logic       vcc_high_in,
  input  wire logic       vpp_high_in,
  input  wire logic       oe_n_in,
  input  wire logic [7:0] upper_in,
  input  wire logic       id_sel_in,
  input  wire logic       id_hv_in,
  input  wire logic [7:0] ctl_data_in,
  input  wire logic       ctl_oe_in,
  output logic [7:0]      lines_out
);
  logic [7:0] mem [0:3];
  int         cnt [0:3];
  int         need [0:3]; // pulses a cell needs before it takes, set by the bench
  int         low_len, width_err, seq_err, id_err;
  logic [7:0] lat, last, drive, held;
  logic       dev_en, pulse_vpp;
  // pin at 13 v is not a low enable, so no read while vpp is up
  assign dev_en = !oe_n_in && !vpp_high_in;
  assign drive = id_hv_in ? (id_sel_in ? DEVICE_CODE : MAKER_CODE) : mem[lat[1:0]];
  // released lines show a changing pattern, never the last value
  assign lines_out = ctl_oe_in ? ctl_data_in : (dev_en ? drive : ~last);
  // pulse measuring, programming and pin misuse counting
  always @(posedge sys_clk_in)
  begin
    last <= lines_out;
    if (reset_in)
    begin
      low_len <= 0; width_err <= 0; seq_err <= 0; id_err <= 0; lat <= 8'h00;
      held <= 8'h00; pulse_vpp <= 1'b0;
      for (int i = 0; i < 4; i++)
      begin
        mem[i] <= 8'hff;
        cnt[i] <= 0;
      end
    end
    else
    begin
      // lines and vpp are taken while the strobe is low, not after it rises
      if (!strobe_in)
      begin
        low_len   <= low_len + 1;
        held      <= ctl_data_in;
        pulse_vpp <= vpp_high_in;
      end
      else if (low_len != 0)
      begin
        low_len <= 0;
        if (low_len < 100)
          lat <= held; // short pulse latches the low address
        else if (pulse_vpp)
        begin
          if (low_len < 475 || low_len > 525)
            width_err <= width_err + 1;
          cnt[lat[1:0]] <= cnt[lat[1:0]] + 1;
          if (cnt[lat[1:0]] + 1 >= need[lat[1:0]])
            mem[lat[1:0]] <= mem[lat[1:0]] & held;
        end
      end
      if ((vpp_high_in && !vcc_high_in) || (ctl_oe_in && dev_en))
        seq_err <= seq_err + 1;
      if (!oe_n_in && id_hv_in && upper_in != 8'h00)
        id_err <= id_err + 1;
    end
  end
endmodule : oep_dev_model

//--- dv/testbench.sv
// self-checking bench for the eprom programmer with a four-byte device model
// assumes LAST_ADDR shortened to 3 and source data computed from the address
`timescale 1ns/1ps
module testbench;
  import oep_pkg::*;
  localparam logic [7:0] MAKER = 8'h5c; // arbitrary value
  localparam logic [7:0] DEVT  = 8'h3a; // arbitrary value
  logic        sys_clk_in, reset_in, start_in, id_req_in, id_sel_in;
  logic [7:0]  src_data_in, lines, ctl_data, id_code_out, upper;
  logic [15:0] src_addr_out;
  logic        busy_out, pass_out, fail_out, strobe, vcc_h, vcc_l, vpp_h, oe_n, ids, idhv, ctl_oe;
  int          bad_count, compares, cycles;
  assign src_data_in = src_addr_out[7:0] ^ 8'ha5;
  oep_prog #(.LAST_ADDR(17'h00003)) u_oep_prog (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .start_in(start_in), .id_req_in(id_req_in), .id_sel_in(id_sel_in),
    .src_data_in(src_data_in), .src_addr_out(src_addr_out), .busy_out(busy_out),
    .pass_out(pass_out), .fail_out(fail_out), .id_code_out(id_code_out), .strobe_out(strobe),
    .vcc_high_out(vcc_h), .vcc_low_out(vcc_l), .vpp_high_out(vpp_h), .oe_n_out(oe_n),
    .upper_address_lines_out(upper), .id_select_line_out(ids),
    .id_mode_high_voltage_line_out(idhv), .muxed_low_address_data_lines_in(lines),
    .muxed_low_address_data_lines_out(ctl_data), .muxed_low_address_data_lines_oe_out(ctl_oe));
  oep_dev_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVT)) u_oep_dev_model (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .strobe_in(strobe), .vcc_high_in(vcc_h),
    .vpp_high_in(vpp_h), .oe_n_in(oe_n), .upper_in(upper), .id_sel_in(ids), .id_hv_in(idhv),
    .ctl_data_in(ctl_data), .ctl_oe_in(ctl_oe), .lines_out(lines));
  initial sys_clk_in = 1'b0;
  always #50 sys_clk_in = ~sys_clk_in;
  // hang guard well above the longest run
  always @(posedge sys_clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      bad_count++;
      final_report();
    end
  end
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task final_report();
    if (bad_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // fresh part in the socket, with per-cell pulse needs
  task do_reset(input int n0, input int n1, input int n2, input int n3);
    @(negedge sys_clk_in) reset_in = 1'b1;
    repeat (8) @(negedge sys_clk_in);
    reset_in = 1'b0;
    u_oep_dev_model.need = '{n0, n1, n2, n3};
  endtask : do_reset
  // request held until busy has come and gone, then released to leave done
  task run_op(input logic prog, input logic sel);
    int n;
    n = 0;
    id_sel_in = sel;
    if (prog)
      start_in = 1'b1;
    else
      id_req_in = 1'b1;
    @(negedge sys_clk_in);
    while (busy_out !== 1'b1 && n < 10)
    begin
      @(negedge sys_clk_in);
      n++;
    end
    while (busy_out !== 1'b0 && n < 50000)
    begin
      @(negedge sys_clk_in);
      n++;
    end
    check("busy", busy_out, 1'b0);
    start_in = 1'b0;
    id_req_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
  endtask : run_op
  task t_prog_pass;
    do_reset(1, 3, 11, 2);
    run_op(1'b1, 1'b0);
    check("pass", pass_out, 1'b1);
    check("fail", fail_out, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      check("cell", u_oep_dev_model.mem[i], i[7:0] ^ 8'ha5);
      check("pulses", u_oep_dev_model.cnt[i], u_oep_dev_model.need[i]);
    end
    check("width", u_oep_dev_model.width_err, 0);
    check("supply order", u_oep_dev_model.seq_err, 0);
    check("vpp off", vpp_h, 1'b0);
    check("core off", vcc_h, 1'b0);
    check("core 5v", vcc_l, 1'b1);
  endtask : t_prog_pass
  task t_prog_fail;
    do_reset(1, 1, 99, 1);
    run_op(1'b1, 1'b0);
    check("fail", fail_out, 1'b1);
    check("pass", pass_out, 1'b0);
    check("pulse limit", u_oep_dev_model.cnt[2], 11);
    check("first pass", u_oep_dev_model.cnt[3], 1);
  endtask : t_prog_fail
  task t_id;
    do_reset(1, 1, 1, 1);
    run_op(1'b0, 1'b0);
    check("maker id", id_code_out, MAKER);
    run_op(1'b0, 1'b1);
    check("device id", id_code_out, DEVT);
    check("id lines", u_oep_dev_model.id_err, 0);
  endtask : t_id
  // inputs settled at time zero, sequence driven on falling edges
  initial
  begin
    reset_in = 1'b1;
    start_in = 1'b0;
    id_req_in = 1'b0;
    id_sel_in = 1'b0;
    bad_count = 0;
    compares = 0;
    t_prog_pass;
    t_prog_fail;
    t_id;
    final_report();
  end
endmodule : testbench
